// File: bench/bfu_host.sv
// bus master standing in for the sequencer and operand fetch logic
module bfu_host (
  // clock and slave answer
  input wire logic i_clk,
  input wire logic i_waitrequest,
  // master request
  output logic [5:0] o_address,
  output logic o_read,
  output logic o_write,
  output logic [31:0] o_writedata,
  output logic [3:0] o_byteenable
);
  timeunit 1ns;
  timeprecision 1ps;

  // idle bus at time zero
  initial begin
    o_address = 6'h00;
    o_read = 1'b0;
    o_write = 1'b0;
    o_writedata = 32'h0000_0000;
    o_byteenable = 4'hf;
  end

  // one access, held until waitrequest is sampled low at a rising edge
  task automatic access(input logic is_rd, input logic [5:0] a, input logic [31:0] d, input logic [3:0] be);
    @(posedge i_clk);
    o_address <= a;
    o_read <= is_rd;
    o_write <= !is_rd;
    o_writedata <= d;
    o_byteenable <= be;
    @(posedge i_clk);
    while (i_waitrequest !== 1'b0) @(posedge i_clk);
    o_read <= 1'b0;
    o_write <= 1'b0;
    o_writedata <= ~d; // stale data must not look valid
  endtask
endmodule

// File: bench/test_bit_field_insert_set_test.sv
`include "bfu_defines.svh"

module test_bit_field_insert_set_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic [5:0] address;
  logic bus_rd;
  logic bus_wr;
  logic [31:0] wdata;
  logic [31:0] rdata;
  logic [3:0] be;
  logic waitreq;
  logic busy;
  int error_cnt = 0;
  int comparisons = 0;
  integer seed = 32'haa229744;
  logic [31:0] exp_q[$];
  logic [31:0] r0 = 32'h0000_0000;
  logic [31:0] r1 = 32'h0000_0000;
  logic [9:0] opc[3] = '{`BFU_OPC_PROBE, `BFU_OPC_FILL, `BFU_OPC_INSERT};
  logic [2:0] mds[5] = '{3'b000, 3'b010, 3'b101, 3'b110, 3'b111};
  // legal flag, first word, extension word
  logic [32:0] tbl[12] = '{
    {1'b0, `BFU_OPC_INSERT, 6'o10, 16'h0000},
    {1'b0, `BFU_OPC_FILL, 6'o30, 16'h0000},
    {1'b0, `BFU_OPC_PROBE, 6'o40, 16'h0000},
    {1'b0, `BFU_OPC_PROBE, 6'o74, 16'h0000},
    {1'b0, `BFU_OPC_FILL, 6'o72, 16'h0000},
    {1'b0, `BFU_OPC_INSERT, 6'o73, 16'h0000},
    {1'b1, `BFU_OPC_PROBE, 6'o72, 16'h0083},
    {1'b1, `BFU_OPC_PROBE, 6'o73, 16'h0000},
    {1'b0, `BFU_OPC_FILL, 6'o20, 16'h1000},
    {1'b0, `BFU_OPC_PROBE, 6'o20, 16'h0a00},
    {1'b0, `BFU_OPC_INSERT, 6'o20, 16'h0028},
    {1'b0, 10'b1110100111, 6'o20, 16'h0000}
  };

  // 200 MHz clock
  always #2.5 clk = ~clk;

  bfu_top dut (
    .i_clk(clk),
    .i_rstn(rstn),
    .i_address(address),
    .i_read(bus_rd),
    .i_write(bus_wr),
    .i_writedata(wdata),
    .i_byteenable(be),
    .o_readdata(rdata),
    .o_waitrequest(waitreq),
    .o_busy(busy)
  );

  bfu_host host (
    .i_clk(clk),
    .i_waitrequest(waitreq),
    .o_address(address),
    .o_read(bus_rd),
    .o_write(bus_wr),
    .o_writedata(wdata),
    .o_byteenable(be)
  );

  task automatic cmp32(input logic [31:0] e, input logic [31:0] g);
    comparisons++;
    if (g !== e) begin
      error_cnt++;
      $display("ERROR t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask

  task automatic wr(input logic [5:0] a, input logic [31:0] d);
    host.access(1'b0, a, d, 4'hf);
  endtask

  // notes the expected value, then reads
  task automatic rd(input logic [5:0] a, input logic [31:0] e);
    exp_q.push_back(e);
    host.access(1'b1, a, 32'h0000_0000, 4'hf);
  endtask

  // takes the oldest note whenever a read answer stands
  always @(posedge clk) begin
    if (bus_rd === 1'b1 && waitreq === 1'b0) begin
      if (exp_q.size() > 0) begin
        cmp32(exp_q.pop_front(), rdata);
      end else begin
        cmp32(32'hdead_beef, rdata);
      end
    end
  end

  // one operation with random operands, checked against a bitwise field model
  task automatic run_op(input logic [15:0] opw, input logic [15:0] ext, input logic legal);
    logic [63:0] win;
    logic [31:0] m0, m1, src, offd, widd, fld, val, lwi, cc;
    logic [4:0] bo;
    logic [5:0] w;
    logic dreg, ins, prb;
    int p;
    m0 = $random(seed);
    m1 = $random(seed);
    src = $random(seed);
    offd = $random(seed);
    widd = $random(seed);
    cc = {27'h0, 5'($random(seed))};
    dreg = (opw[5:3] == `BFU_EA_DREG);
    ins = (opw[15:6] == `BFU_OPC_INSERT);
    prb = (opw[15:6] == `BFU_OPC_PROBE);
    bo = ext[11] ? offd[4:0] : ext[10:6];
    w = ext[5] ? {1'b0, widd[4:0]} : {1'b0, ext[4:0]};
    if (w == 6'h00) w = 6'h20;
    lwi = (ext[11] && !dreg) ? {{5{offd[31]}}, offd[31:5]} : 32'h0000_0000;
    win = {m0, m1};
    fld = 32'h0000_0000;
    for (int i = 0; i < w; i++) begin
      p = dreg ? (bo + i) % 32 : bo + i;
      fld = {fld[30:0], win[63 - p]};
      if (!prb) win[63 - p] = ins ? src[w - 1 - i] : 1'b1;
    end
    val = ins ? (src & (32'hffff_ffff >> (32 - w))) : fld;
    wr(`BFU_OFF_OPW, {16'h0000, opw});
    wr(`BFU_OFF_EXT, {16'h0000, ext});
    rd(`BFU_OFF_DEC, {21'h0, ext[2:0], 1'b0, ext[8:6], 1'b0, ext[14:12]});
    wr(`BFU_OFF_SRC, src);
    wr(`BFU_OFF_OFFD, offd);
    wr(`BFU_OFF_WIDD, widd);
    wr(`BFU_OFF_MEM0, m0);
    wr(`BFU_OFF_MEM1, m1);
    wr(`BFU_OFF_CCR, cc);
    wr(`BFU_OFF_CTRL, 32'h0000_0001);
    // the execute cycle follows the accepted start write
    @(posedge clk);
    cmp32(32'h0000_0001, {31'h0, busy});
    rd(`BFU_OFF_STAT, legal ? {28'h0, !prb, 3'b010} : 32'h0000_0006);
    if (legal) begin
      r0 = win[63:32];
      r1 = win[31:0];
      cc = {27'h0, cc[4], val[w - 1], val == 32'h0, 2'b00};
    end
    rd(`BFU_OFF_RES0, r0);
    rd(`BFU_OFF_RES1, r1);
    rd(`BFU_OFF_CCR, cc);
    if (legal) rd(`BFU_OFF_LWI, lwi);
  endtask

  task automatic test_done();
    $display("comparisons=%0d error_cnt=%0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // main sequence
  initial begin
    logic [31:0] r, x;
    logic [15:0] e;
    logic [9:0] op;
    logic [2:0] md;
    repeat (12) @(posedge clk);
    rstn <= 1'b1;
    repeat (4) @(posedge clk);
    rd(`BFU_OFF_STAT, 32'h0000_0000);
    rd(6'h38, 32'h0000_0000);
    wr(`BFU_OFF_RES0, 32'h1234_5678);
    rd(`BFU_OFF_RES0, 32'h0000_0000);
    host.access(1'b0, `BFU_OFF_CTRL, 32'h0000_0001, 4'he);
    rd(`BFU_OFF_STAT, 32'h0000_0000);
    foreach (tbl[k]) run_op(tbl[k][31:16], tbl[k][15:0], tbl[k][32]);
    for (int n = 0; n < 150; n++) begin
      r = $random(seed);
      x = $random(seed);
      op = opc[r[7:0] % 3];
      md = mds[r[15:8] % 5];
      e = x[15:0];
      e[15] = 1'b0;
      if (op != `BFU_OPC_INSERT) e[14:12] = 3'h0;
      if (e[11]) e[10:9] = 2'h0;
      if (e[5]) e[4:3] = 2'h0;
      run_op({op, md, (md == 3'b111) ? {2'b00, r[16]} : r[19:17]}, e, 1'b1);
    end
    @(posedge clk);
    test_done();
  end

  // watchdog against a hung handshake
  initial begin
    repeat (20000) @(posedge clk);
    error_cnt++;
    test_done();
  end
endmodule

// File: hdl/bfu_decode.sv
`include "bfu_defines.svh"

// decodes both instruction words into operation, field and legality
module bfu_decode (
  // instruction words
  input wire logic [15:0] i_opw,
  input wire logic [15:0] i_ext,
  // register-held offset and width
  input wire logic [31:0] i_offd,
  input wire logic [31:0] i_widd,
  // decoded results
  output bfu_pkg::bfu_op_t o_op,
  output logic o_legal,
  output logic o_dreg,
  output logic [4:0] o_bitoff,
  output logic [5:0] o_width,
  output logic [31:0] o_lwidx
);

  // legal effective address check; pc forms only for probe
  function automatic logic ea_ok(input logic [2:0] m, input logic [2:0] r, input logic pc);
    logic ok;
    ok = 1'b0;
    if (m == `BFU_EA_DREG || m == `BFU_EA_IND || m == `BFU_EA_DISP || m == `BFU_EA_IDX) begin
      ok = 1'b1;
    end else if (m == `BFU_EA_EXT) begin
      ok = (r == `BFU_EA_ABSW) || (r == `BFU_EA_ABSL) || (pc && (r == `BFU_EA_PCD || r == `BFU_EA_PCX));
    end
    return ok;
  endfunction

  logic [31:0] off_full;
  logic [4:0] wid_code;
  logic rsv_ok;

  always_comb begin
    // opcode in the upper ten bits
    unique case (i_opw[15:6])
      `BFU_OPC_PROBE: o_op = bfu_pkg::BFU_OP_PROBE;
      `BFU_OPC_FILL: o_op = bfu_pkg::BFU_OP_FILL;
      `BFU_OPC_INSERT: o_op = bfu_pkg::BFU_OP_INSERT;
      default: o_op = bfu_pkg::BFU_OP_NONE;
    endcase
    // offset: immediate 0..31 or full signed register value
    off_full = i_ext[11] ? i_offd : {27'h0, i_ext[10:6]};
    // width code 0 means 32, register value taken mod 32
    wid_code = i_ext[5] ? i_widd[4:0] : i_ext[4:0];
    o_width = {(wid_code == 5'h00), wid_code};
    o_dreg = (i_opw[5:3] == `BFU_EA_DREG);
    o_bitoff = off_full[4:0];
    // long word holding the first field bit, memory forms only
    o_lwidx = o_dreg ? 32'h0 : 32'($signed(off_full) >>> 5);
    // reserved extension bits must be zero
    rsv_ok = !(i_ext[11] && i_ext[10:9] != 2'b00) && !(i_ext[5] && i_ext[4:3] != 2'b00);
    if (o_op == bfu_pkg::BFU_OP_INSERT) begin
      rsv_ok = rsv_ok && !i_ext[15];
    end else begin
      rsv_ok = rsv_ok && (i_ext[15:12] == 4'h0);
    end
    o_legal = (o_op != bfu_pkg::BFU_OP_NONE) && rsv_ok
      && ea_ok(i_opw[5:3], i_opw[2:0], o_op == bfu_pkg::BFU_OP_PROBE);
  end

endmodule

// File: hdl/bfu_defines.svh
`ifndef BFU_DEFINES_SVH
`define BFU_DEFINES_SVH

// register byte offsets
`define BFU_OFF_OPW 6'h00
`define BFU_OFF_EXT 6'h04
`define BFU_OFF_SRC 6'h08
`define BFU_OFF_OFFD 6'h0c
`define BFU_OFF_WIDD 6'h10
`define BFU_OFF_MEM0 6'h14
`define BFU_OFF_MEM1 6'h18
`define BFU_OFF_CTRL 6'h1c
`define BFU_OFF_CCR 6'h20
`define BFU_OFF_RES0 6'h24
`define BFU_OFF_RES1 6'h28
`define BFU_OFF_STAT 6'h2c
`define BFU_OFF_DEC 6'h30
`define BFU_OFF_LWI 6'h34

// control and flag bit positions
`define BFU_CTRL_START 0
`define BFU_CTRL_CLRDONE 1
`define BFU_CCR_X 4
`define BFU_CCR_N 3
`define BFU_CCR_Z 2
`define BFU_CCR_V 1
`define BFU_CCR_C 0

// first-word opcodes, bits 15..6
`define BFU_OPC_PROBE 10'b1110100011
`define BFU_OPC_FILL 10'b1110111011
`define BFU_OPC_INSERT 10'b1110111111

// effective address modes
`define BFU_EA_DREG 3'b000
`define BFU_EA_IND 3'b010
`define BFU_EA_DISP 3'b101
`define BFU_EA_IDX 3'b110
`define BFU_EA_EXT 3'b111
`define BFU_EA_ABSW 3'b000
`define BFU_EA_ABSL 3'b001
`define BFU_EA_PCD 3'b010
`define BFU_EA_PCX 3'b011

// reset values
`define BFU_RST_WORD 32'h0000_0000
`define BFU_RST_HALF 16'h0000

`endif

// File: hdl/bfu_field.sv
// field datapath over a 64-bit window, offset 0 is the msb of word 0
module bfu_field (
  // operands
  input wire logic [31:0] i_word0,
  input wire logic [31:0] i_word1,
  input wire logic [31:0] i_src,
  // field selection
  input wire logic i_dreg,
  input wire logic [4:0] i_bitoff,
  input wire logic [5:0] i_width,
  input bfu_pkg::bfu_op_t i_op,
  // results
  output logic [31:0] o_res0,
  output logic [31:0] o_res1,
  output logic o_n,
  output logic o_z
);

  logic [63:0] win, mask, ins, upd, sh, sel;
  logic [31:0] srcl, fld;

  always_comb begin
    // register form wraps inside one long word
    win = i_dreg ? {i_word0, i_word0} : {i_word0, i_word1};
    mask = ~(64'hffff_ffff_ffff_ffff >> i_width) >> i_bitoff;
    srcl = i_src << (6'd32 - i_width);
    ins = {srcl, 32'h0} >> i_bitoff;
    sh = win << i_bitoff;
    fld = sh[63:32] >> (6'd32 - i_width);
    unique case (i_op)
      bfu_pkg::BFU_OP_INSERT: upd = (win & ~mask) | ins;
      bfu_pkg::BFU_OP_FILL: upd = win | mask;
      default: upd = win;
    endcase
    sel = upd & mask;
    // flags from inserted value, else from old field
    if (i_op == bfu_pkg::BFU_OP_INSERT) begin
      o_n = srcl[31];
      o_z = (srcl == 32'h0);
    end else begin
      o_n = sh[63];
      o_z = (fld == 32'h0);
    end
    if (i_dreg) begin
      o_res0 = (i_word0 & ~(mask[63:32] | mask[31:0])) | sel[63:32] | sel[31:0];
      o_res1 = i_word1;
    end else begin
      o_res0 = upd[63:32];
      o_res1 = upd[31:0];
    end
  end

endmodule

// File: hdl/bfu_pkg.sv
package bfu_pkg;

  typedef enum logic [1:0] {
    BFU_OP_NONE = 2'b00,
    BFU_OP_PROBE = 2'b01,
    BFU_OP_FILL = 2'b10,
    BFU_OP_INSERT = 2'b11
  } bfu_op_t;

  typedef enum logic [0:0] {
    BFU_S_IDLE = 1'b0,
    BFU_S_EXEC = 1'b1
  } bfu_state_t;

  typedef struct packed {
    bfu_state_t state;
    logic [15:0] opw;
    logic [15:0] ext;
    logic [31:0] src;
    logic [31:0] offd;
    logic [31:0] widd;
    logic [31:0] mem0;
    logic [31:0] mem1;
    logic [31:0] res0;
    logic [31:0] res1;
    logic [31:0] lwidx;
    logic [31:0] rdata;
    logic wait_req;
    logic xf;
    logic nf;
    logic zf;
    logic vf;
    logic cf;
    logic done;
    logic illegal;
    logic wb;
  } bfu_state_s_t;

endpackage

// File: hdl/bfu_top.sv
// How it works
// - insert writes source low bits into field
// - insert flags come from inserted value
// - fill sets field ones, flags from old
// - probe updates flags only, no writeback
// - n is field msb; v,c cleared; x kept
// - z set when field value is zero
// - offset is first bit, width is count
// - offset from immediate or selected data register
// - immediate offset unsigned 0 to 31
// - register offset is full signed 32-bit
// - width from immediate or selected data register
// - immediate width zero means 32 bits
// - register width taken modulo 32
// - insert, fill: only alterable control or register
// - probe also allows pc-relative control modes
// - insert source reg in 14..12, else zero
`include "bfu_defines.svh"

module bfu_top (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rstn,
  // avalon-mm slave
  input wire logic [5:0] i_address,
  input wire logic i_read,
  input wire logic i_write,
  input wire logic [31:0] i_writedata,
  input wire logic [3:0] i_byteenable,
  output logic [31:0] o_readdata,
  output logic o_waitrequest,
  // status
  output logic o_busy
);

  // merge write data under byte enables
  function automatic logic [31:0] be_merge(input logic [31:0] old, input logic [31:0] wd,
                                           input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        r[i*8 +: 8] = wd[i*8 +: 8];
      end
    end
    return r;
  endfunction

  logic [1:0] rsync;
  logic rstn_q;
  bfu_pkg::bfu_state_s_t st;
  bfu_pkg::bfu_state_s_t next_st;
  bfu_pkg::bfu_op_t dec_op;
  logic dec_legal;
  logic dec_dreg;
  logic [4:0] dec_bitoff;
  logic [5:0] dec_width;
  logic [31:0] dec_lwidx;
  logic [31:0] f_res0;
  logic [31:0] f_res1;
  logic f_n;
  logic f_z;
  logic acc;
  logic wr_acc;
  logic start_req;
  logic [31:0] rd_mux;

  // reset release through two flops
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      rsync <= 2'b00;
    end else begin
      rsync <= {rsync[0], 1'b1};
    end
  end
  assign rstn_q = rsync[1];

  // instruction decode
  bfu_decode u_decode (
    .i_opw(st.opw),
    .i_ext(st.ext),
    .i_offd(st.offd),
    .i_widd(st.widd),
    .o_op(dec_op),
    .o_legal(dec_legal),
    .o_dreg(dec_dreg),
    .o_bitoff(dec_bitoff),
    .o_width(dec_width),
    .o_lwidx(dec_lwidx)
  );

  // field datapath
  bfu_field u_field (
    .i_word0(st.mem0),
    .i_word1(st.mem1),
    .i_src(st.src),
    .i_dreg(dec_dreg),
    .i_bitoff(dec_bitoff),
    .i_width(dec_width),
    .i_op(dec_op),
    .o_res0(f_res0),
    .o_res1(f_res1),
    .o_n(f_n),
    .o_z(f_z)
  );

  // bus handshake terms
  assign acc = (i_read || i_write) && !st.wait_req;
  assign wr_acc = i_write && !st.wait_req;
  assign start_req = wr_acc && (i_address == `BFU_OFF_CTRL) && i_byteenable[0]
    && i_writedata[`BFU_CTRL_START];

  // read multiplexer
  always_comb begin
    rd_mux = 32'h0;
    unique case (i_address)
      `BFU_OFF_OPW: rd_mux = {16'h0, st.opw};
      `BFU_OFF_EXT: rd_mux = {16'h0, st.ext};
      `BFU_OFF_SRC: rd_mux = st.src;
      `BFU_OFF_OFFD: rd_mux = st.offd;
      `BFU_OFF_WIDD: rd_mux = st.widd;
      `BFU_OFF_MEM0: rd_mux = st.mem0;
      `BFU_OFF_MEM1: rd_mux = st.mem1;
      `BFU_OFF_CCR: rd_mux = {27'h0, st.xf, st.nf, st.zf, st.vf, st.cf};
      `BFU_OFF_RES0: rd_mux = st.res0;
      `BFU_OFF_RES1: rd_mux = st.res1;
      `BFU_OFF_STAT: rd_mux = {28'h0, st.wb, st.illegal, st.done, st.state == bfu_pkg::BFU_S_EXEC};
      // decoded register numbers for the operand fetch
      `BFU_OFF_DEC: rd_mux = {21'h0, st.ext[2:0], 1'b0, st.ext[8:6], 1'b0, st.ext[14:12]};
      `BFU_OFF_LWI: rd_mux = st.lwidx;
      default: rd_mux = 32'h0;
    endcase
  end

  // next state
  always_comb begin
    next_st = st;
    // one wait cycle, then the answer
    next_st.wait_req = st.wait_req ? !(i_read || i_write) : 1'b1;
    if (st.wait_req && i_read) begin
      next_st.rdata = rd_mux;
    end
    if (wr_acc) begin
      unique case (i_address)
        `BFU_OFF_OPW: next_st.opw = 16'(be_merge({16'h0, st.opw}, i_writedata, i_byteenable));
        `BFU_OFF_EXT: next_st.ext = 16'(be_merge({16'h0, st.ext}, i_writedata, i_byteenable));
        `BFU_OFF_SRC: next_st.src = be_merge(st.src, i_writedata, i_byteenable);
        `BFU_OFF_OFFD: next_st.offd = be_merge(st.offd, i_writedata, i_byteenable);
        `BFU_OFF_WIDD: next_st.widd = be_merge(st.widd, i_writedata, i_byteenable);
        `BFU_OFF_MEM0: next_st.mem0 = be_merge(st.mem0, i_writedata, i_byteenable);
        `BFU_OFF_MEM1: next_st.mem1 = be_merge(st.mem1, i_writedata, i_byteenable);
        `BFU_OFF_CCR: begin
          if (i_byteenable[0]) begin
            next_st.xf = i_writedata[`BFU_CCR_X];
            next_st.nf = i_writedata[`BFU_CCR_N];
            next_st.zf = i_writedata[`BFU_CCR_Z];
            next_st.vf = i_writedata[`BFU_CCR_V];
            next_st.cf = i_writedata[`BFU_CCR_C];
          end
        end
        `BFU_OFF_CTRL: begin
          if (i_byteenable[0] && i_writedata[`BFU_CTRL_CLRDONE]) begin
            next_st.done = 1'b0;
          end
        end
        default: next_st.opw = st.opw;
      endcase
    end
    // operation sequencing
    unique case (st.state)
      bfu_pkg::BFU_S_IDLE: begin
        if (start_req) begin
          next_st.state = bfu_pkg::BFU_S_EXEC;
          next_st.done = 1'b0;
          next_st.illegal = 1'b0;
          next_st.wb = 1'b0;
        end
      end
      bfu_pkg::BFU_S_EXEC: begin
        next_st.state = bfu_pkg::BFU_S_IDLE;
        next_st.done = 1'b1; // set wins over a same-cycle clear
        next_st.illegal = !dec_legal;
        if (dec_legal) begin
          next_st.wb = (dec_op != bfu_pkg::BFU_OP_PROBE);
          next_st.res0 = f_res0;
          next_st.res1 = f_res1;
          next_st.lwidx = dec_lwidx;
          next_st.nf = f_n;
          next_st.zf = f_z;
          next_st.vf = 1'b0;
          next_st.cf = 1'b0;
        end
      end
    endcase
  end

  // state register
  always_ff @(posedge i_clk or negedge rstn_q) begin
    if (!rstn_q) begin
      st <= '{state: bfu_pkg::BFU_S_IDLE, opw: `BFU_RST_HALF, ext: `BFU_RST_HALF,
              src: `BFU_RST_WORD, offd: `BFU_RST_WORD, widd: `BFU_RST_WORD,
              mem0: `BFU_RST_WORD, mem1: `BFU_RST_WORD, res0: `BFU_RST_WORD,
              res1: `BFU_RST_WORD, lwidx: `BFU_RST_WORD, rdata: `BFU_RST_WORD,
              wait_req: 1'b1, default: 1'b0};
    end else begin
      st <= next_st;
    end
  end

  // outputs straight from flops
  assign o_readdata = st.rdata;
  assign o_waitrequest = st.wait_req;
  assign o_busy = (st.state == bfu_pkg::BFU_S_EXEC);

  // independent reference terms for the checks
  logic chk_n;
  logic chk_z;
  logic exec_ok;
  assign chk_n = |(st.src & (32'h1 << (dec_width - 6'd1)));
  assign chk_z = ((st.src & ~(32'hffff_ffff << dec_width)) == 32'h0) || (dec_width == 6'd32 && st.src == 32'h0);
  assign exec_ok = (st.state == bfu_pkg::BFU_S_EXEC) && dec_legal;

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!rstn_q);

  sequence s_start;
    st.state == bfu_pkg::BFU_S_IDLE && start_req;
  endsequence

  sequence s_run_done;
    o_busy ##1 (st.done && !o_busy);
  endsequence

  a_bus_answer: assert property ((i_read || i_write) && o_waitrequest |=> !o_waitrequest)
    else $error("bus request not answered after one wait cycle");

  a_start_done: assert property (s_start |=> s_run_done)
    else $error("operation did not finish two cycles after start");

  a_vc_clear: assert property (exec_ok |=> !st.vf && !st.cf)
    else $error("overflow or carry not cleared");

  a_x_kept: assert property (o_busy |=> $stable(st.xf))
    else $error("extend flag changed by the operation");

  a_probe_nowb: assert property (exec_ok && dec_op == bfu_pkg::BFU_OP_PROBE |=> !st.wb)
    else $error("probe requested a writeback");

  a_ins_flags: assert property (exec_ok && dec_op == bfu_pkg::BFU_OP_INSERT
    |=> st.nf == $past(chk_n) && st.zf == $past(chk_z))
    else $error("insert flags do not follow the inserted value");

  a_fill_first: assert property (exec_ok && dec_op == bfu_pkg::BFU_OP_FILL && !dec_dreg
    |=> st.res0[5'd31 - $past(dec_bitoff)])
    else $error("first field bit not set by fill");

  a_rsv_reject: assert property (o_busy && st.ext[11] && st.ext[10:9] != 2'b00
    |=> st.illegal && !st.wb)
    else $error("reserved offset bits accepted");

  a_ea_reject: assert property (o_busy && st.opw[5:3] == 3'b001 ##1 1'b1
    |-> st.illegal && $stable(st.res0))
    else $error("address register direct accepted");

endmodule
